//--- logic/dual_uart_pin_control.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Enable bit set: interrupt pin driven, auxiliary output low.
// - Enable bit clear: interrupt pin floats, auxiliary output high.
// - Enable bit resets to zero: pins float and auxiliary outputs high.
// - Each channel owns its enable bit and pins, independent of the other.
// - Request-to-send output is active low, software controlled.
// - Terminal-ready output is active low, software controlled.
// - Handshake inputs are active low and never affect transmit or receive.
module dual_uart_pin_control
  import uart_pins_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Channel A control side
  input wire logic chan_a_ctl_wr,
  input wire logic [CTL_WIDTH-1:0] chan_a_ctl_wdata,
  output logic [CTL_WIDTH-1:0] chan_a_modem_control,
  input wire logic chan_a_irq_req,
  input wire logic chan_a_tx_valid,
  input wire logic [7:0] chan_a_tx_data,
  output logic chan_a_tx_ready,
  output modem_in_s chan_a_modem_status,
  output logic chan_a_rx_level,
  // Channel A pins
  output logic chan_a_irq_out,
  output logic chan_a_irq_oe,
  output logic chan_a_aux_out_n,
  output logic chan_a_serial_out,
  input wire logic chan_a_serial_in,
  output logic chan_a_request_send_n,
  output logic chan_a_terminal_ready_n,
  input wire logic chan_a_clear_send_n,
  input wire logic chan_a_set_ready_n,
  input wire logic chan_a_carrier_n,
  input wire logic chan_a_ring_n,
  // Channel B control side
  input wire logic chan_b_ctl_wr,
  input wire logic [CTL_WIDTH-1:0] chan_b_ctl_wdata,
  output logic [CTL_WIDTH-1:0] chan_b_modem_control,
  input wire logic chan_b_irq_req,
  input wire logic chan_b_tx_valid,
  input wire logic [7:0] chan_b_tx_data,
  output logic chan_b_tx_ready,
  output modem_in_s chan_b_modem_status,
  output logic chan_b_rx_level,
  // Channel B pins
  output logic chan_b_irq_out,
  output logic chan_b_irq_oe,
  output logic chan_b_aux_out_n,
  output logic chan_b_serial_out,
  input wire logic chan_b_serial_in,
  output logic chan_b_request_send_n,
  output logic chan_b_terminal_ready_n,
  input wire logic chan_b_clear_send_n,
  input wire logic chan_b_set_ready_n,
  input wire logic chan_b_carrier_n,
  input wire logic chan_b_ring_n
);

  // ----------------------------------------
  // Per-channel state, indexed 0 = A, 1 = B
  // ----------------------------------------
  logic [CTL_WIDTH-1:0] modem_control_reg [NUM_CHAN];
  logic irq_reg [NUM_CHAN];
  modem_in_s status_reg [NUM_CHAN];
  tx_state_e tx_state_reg [NUM_CHAN];
  logic [FRAME_BITS-1:0] tx_shift_reg [NUM_CHAN];
  logic [BIT_CNT_W-1:0] tx_bits_reg [NUM_CHAN];
  logic [CYC_CNT_W-1:0] tx_cyc_reg [NUM_CHAN];
  logic tx_line_reg [NUM_CHAN];

  logic ctl_wr [NUM_CHAN];
  logic [CTL_WIDTH-1:0] ctl_wdata [NUM_CHAN];
  logic irq_req [NUM_CHAN];
  logic tx_valid [NUM_CHAN];
  logic [7:0] tx_data [NUM_CHAN];
  logic tx_ready [NUM_CHAN];
  logic [SYNC_WIDTH-1:0] pins_raw [NUM_CHAN];
  logic [SYNC_WIDTH-1:0] pins_sync [NUM_CHAN];

  // Builds the 8N1 frame, start bit in the low position
  function automatic logic [FRAME_BITS-1:0] make_frame(input logic [7:0] data);
    make_frame = {1'b1, data, 1'b0};
  endfunction

  // ----------------------------------------
  // Port gathering into channel arrays
  // ----------------------------------------
  assign ctl_wr[0] = chan_a_ctl_wr;
  assign ctl_wr[1] = chan_b_ctl_wr;
  assign ctl_wdata[0] = chan_a_ctl_wdata;
  assign ctl_wdata[1] = chan_b_ctl_wdata;
  assign irq_req[0] = chan_a_irq_req;
  assign irq_req[1] = chan_b_irq_req;
  assign tx_valid[0] = chan_a_tx_valid;
  assign tx_valid[1] = chan_b_tx_valid;
  assign tx_data[0] = chan_a_tx_data;
  assign tx_data[1] = chan_b_tx_data;
  assign pins_raw[0] = {chan_a_serial_in, chan_a_clear_send_n, chan_a_set_ready_n, chan_a_carrier_n, chan_a_ring_n};
  assign pins_raw[1] = {chan_b_serial_in, chan_b_clear_send_n, chan_b_set_ready_n, chan_b_carrier_n, chan_b_ring_n};

  // ----------------------------------------
  // Pin input retiming, one synchroniser per channel
  // ----------------------------------------
  pin_sync2 u_sync_a (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in(pins_raw[0]),
    .sync_out(pins_sync[0])
  );

  pin_sync2 u_sync_b (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in(pins_raw[1]),
    .sync_out(pins_sync[1])
  );

  // Modem control register, one private copy per channel
  always_ff @(posedge clk)
  begin
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      if (rst)
        modem_control_reg[c] <= CTL_RESET;
      else if (ce && ctl_wr[c])
        modem_control_reg[c] <= ctl_wdata[c];
    end
  end

  // Interrupt level registered; it only reaches the pin while enabled
  always_ff @(posedge clk)
  begin
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      if (rst)
        irq_reg[c] <= 1'b0;
      else if (ce)
        irq_reg[c] <= irq_req[c];
    end
  end

  // Status snapshot of the handshake inputs, for reading only
  always_ff @(posedge clk)
  begin
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      if (rst)
        status_reg[c] <= '1;
      else if (ce)
        status_reg[c] <= modem_in_s'(pins_sync[c][SYNC_WIDTH-2:0]);
    end
  end

  // Transmitter; deliberately blind to clear-to-send and friends
  always_ff @(posedge clk)
  begin
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      if (rst)
      begin
        tx_state_reg[c] <= TX_IDLE;
        tx_shift_reg[c] <= '1;
        tx_bits_reg[c] <= '0;
        tx_cyc_reg[c] <= '0;
        tx_line_reg[c] <= 1'b1;
      end
      else if (ce)
      begin
        case (tx_state_reg[c])
          TX_IDLE:
          begin
            tx_line_reg[c] <= 1'b1;
            if (tx_valid[c])
            begin
              tx_shift_reg[c] <= make_frame(tx_data[c]);
              tx_bits_reg[c] <= '0;
              tx_cyc_reg[c] <= '0;
              tx_state_reg[c] <= TX_SHIFT;
            end
          end
          TX_SHIFT:
          begin
            tx_line_reg[c] <= tx_shift_reg[c][0];
            if (tx_cyc_reg[c] == CYC_CNT_W'(BIT_CYCLES - 1))
            begin
              tx_cyc_reg[c] <= '0;
              tx_shift_reg[c] <= {1'b1, tx_shift_reg[c][FRAME_BITS-1:1]};
              if (tx_bits_reg[c] == BIT_CNT_W'(FRAME_BITS - 1))
                tx_state_reg[c] <= TX_IDLE;
              else
                tx_bits_reg[c] <= tx_bits_reg[c] + 1'b1;
            end
            else
              tx_cyc_reg[c] <= tx_cyc_reg[c] + 1'b1;
          end
          default:
            tx_state_reg[c] <= TX_IDLE;
        endcase
      end
    end
  end

  // Ready is combinational so a new byte can load on the idle cycle
  always_comb
  begin
    for (int c = 0; c < NUM_CHAN; c++)
      tx_ready[c] = (tx_state_reg[c] == TX_IDLE);
  end

  // ----------------------------------------
  // Pin outputs; aux pin is tied to the irq enable, not free for use
  // ----------------------------------------
  assign chan_a_irq_out = irq_reg[0];
  assign chan_a_irq_oe = modem_control_reg[0][CTL_IRQ_EN_BIT];
  assign chan_a_aux_out_n = ~modem_control_reg[0][CTL_IRQ_EN_BIT];
  assign chan_a_request_send_n = ~modem_control_reg[0][CTL_RTS_BIT];
  assign chan_a_terminal_ready_n = ~modem_control_reg[0][CTL_DTR_BIT];
  assign chan_a_serial_out = tx_line_reg[0];
  assign chan_a_tx_ready = tx_ready[0];
  assign chan_a_modem_status = status_reg[0];
  assign chan_a_modem_control = modem_control_reg[0];
  assign chan_a_rx_level = pins_sync[0][SYNC_WIDTH-1];
  assign chan_b_irq_out = irq_reg[1];
  assign chan_b_irq_oe = modem_control_reg[1][CTL_IRQ_EN_BIT];
  assign chan_b_aux_out_n = ~modem_control_reg[1][CTL_IRQ_EN_BIT];
  assign chan_b_request_send_n = ~modem_control_reg[1][CTL_RTS_BIT];
  assign chan_b_terminal_ready_n = ~modem_control_reg[1][CTL_DTR_BIT];
  assign chan_b_serial_out = tx_line_reg[1];
  assign chan_b_tx_ready = tx_ready[1];
  assign chan_b_modem_status = status_reg[1];
  assign chan_b_modem_control = modem_control_reg[1];
  assign chan_b_rx_level = pins_sync[1][SYNC_WIDTH-1];

  // ----------------------------------------
  // Checks on channel A pins; the reset and independence checks also cover channel B
  // ----------------------------------------
  sequence s_en_written;
    ce && chan_a_ctl_wr && chan_a_ctl_wdata[CTL_IRQ_EN_BIT];
  endsequence

  sequence s_pin_driven;
    chan_a_irq_oe && !chan_a_aux_out_n;
  endsequence

  a_irq_drive_on: assert property (@(posedge clk) disable iff (rst)
    s_en_written |=> s_pin_driven)
    else $error("irq pin not driven after enable write");

  a_irq_float_off: assert property (@(posedge clk) disable iff (rst)
    (ce && chan_a_ctl_wr && !chan_a_ctl_wdata[CTL_IRQ_EN_BIT]) |=> (!chan_a_irq_oe && chan_a_aux_out_n))
    else $error("irq pin not floated after disable write");

  a_reset_default_off: assert property (@(posedge clk)
    $past(rst) |-> (!chan_a_irq_oe && chan_a_aux_out_n && !chan_b_irq_oe && chan_b_aux_out_n))
    else $error("irq enable not clear after reset");

  a_chan_indep_b: assert property (@(posedge clk) disable iff (rst)
    (ce && chan_a_ctl_wr && !chan_b_ctl_wr) |=> $stable(chan_b_modem_control))
    else $error("channel B control moved on channel A write");

  a_rts_follow_ctl: assert property (@(posedge clk) disable iff (rst)
    (ce && chan_a_ctl_wr) |=> (chan_a_request_send_n == !$past(chan_a_ctl_wdata[CTL_RTS_BIT])))
    else $error("request-to-send does not follow control bit");

  a_dtr_follow_ctl: assert property (@(posedge clk) disable iff (rst)
    (ce && chan_a_ctl_wr) |=> (chan_a_terminal_ready_n == !$past(chan_a_ctl_wdata[CTL_DTR_BIT])))
    else $error("terminal-ready does not follow control bit");

  a_tx_ignores_cts: assert property (@(posedge clk) disable iff (rst)
    (ce && chan_a_tx_ready && chan_a_tx_valid) |=> !chan_a_tx_ready)
    else $error("transmit start blocked");

  a_tx_idle_mark: assert property (@(posedge clk) disable iff (rst)
    (chan_a_tx_ready && $past(chan_a_tx_ready)) |-> chan_a_serial_out)
    else $error("transmit line not at mark while idle");

  a_status_follow_pins: assert property (@(posedge clk) disable iff (rst)
    (ce [*4]) |-> (chan_a_modem_status.cts_n == $past(chan_a_clear_send_n, 3)))
    else $error("status does not track clear-to-send pin");

endmodule

`default_nettype wire

//--- logic/uart_pins_pkg.sv
`default_nettype none

package uart_pins_pkg;

  // ----------------------------------------
  // Modem control register layout
  // ----------------------------------------
  localparam int CTL_WIDTH = 4;
  localparam int CTL_DTR_BIT = 0;
  localparam int CTL_RTS_BIT = 1;
  localparam int CTL_OUT1_BIT = 2;
  localparam int CTL_IRQ_EN_BIT = 3;
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 4'h0;

  // ----------------------------------------
  // Channel count and input synchroniser
  // ----------------------------------------
  localparam int NUM_CHAN = 2;
  localparam int SYNC_WIDTH = 5;

  // ----------------------------------------
  // Serial timing, 8N1 frame
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_TIME_NS = 1000;
  localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int CYC_CNT_W = 7;
  localparam int FRAME_BITS = 10;
  localparam int BIT_CNT_W = 4;

  // Modem inputs, all active low, as seen on the pins
  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic cd_n;
    logic ri_n;
  } modem_in_s;

  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} tx_state_e;

endpackage

`default_nettype wire

//--- logic/pin_sync2.sv
`timescale 1ns/100ps
`default_nettype none

module pin_sync2
  import uart_pins_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Asynchronous levels in, retimed levels out
  input wire logic [SYNC_WIDTH-1:0] async_in,
  output logic [SYNC_WIDTH-1:0] sync_out
);

  logic [SYNC_WIDTH-1:0] stage1_reg;

  // Two-flop retiming; reset to idle-high like an unused pulled-up pin
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1_reg <= '1;
      sync_out <= '1;
    end
    else if (ce)
    begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end

endmodule

`default_nettype wire

//--- dv/serial_term_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Far-end serial terminal, one channel
// ----------------------------------------
module serial_term_model
  import uart_pins_pkg::*;
(
  // Line from the device
  input wire logic line_in,
  // Line to the device
  output logic line_out,
  // Last decoded frame
  output logic [7:0] rx_byte,
  output logic stop_ok,
  output int rx_count
);
  // Nothing is sent from this end, so the line rests at mark
  assign line_out = 1'b1;

  // Mid-bit sampling, one ns past the edge to stay clear of the launch edge
  initial
  begin
    rx_byte = 8'h00;
    stop_ok = 1'b0;
    rx_count = 0;
    forever
    begin
      @(negedge line_in);
      #(BIT_TIME_NS + BIT_TIME_NS / 2 + 1);
      for (int i = 0; i < 8; i++)
      begin
        rx_byte[i] = line_in;
        #(BIT_TIME_NS);
      end
      stop_ok = line_in;
      rx_count++;
    end
  end
endmodule

`default_nettype wire

//--- dv/test_dual_uart_pin_control.sv
`timescale 1ns/100ps
`default_nettype none

module test_dual_uart_pin_control
  import uart_pins_pkg::*;
;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [1:0] wr = 2'h0;
  logic [1:0] irq_req = 2'h0;
  logic [1:0] tx_valid = 2'h0;
  logic [CTL_WIDTH-1:0] wd [2] = '{default: '0};
  logic [CTL_WIDTH-1:0] mexp [2] = '{default: '0};
  logic [7:0] txd [2] = '{default: '0};
  modem_in_s hs [2] = '{default: '1};
  logic [CTL_WIDTH-1:0] mc [2];
  modem_in_s st [2];
  logic rdy [2], rxl [2], irq [2], oe [2], aux [2], sout [2], sin [2], rts [2], dtr [2];
  logic [7:0] rb [2];
  logic stop_ok [2];
  int rc [2];
  int n_errors = 0;
  int n_tests = 0;
  int c, n;
  logic [7:0] b;

  always #5 clk = ~clk;

  // Auxiliary outputs are loaded into aux and checked by chk_pins
  dual_uart_pin_control dual_uart_pin_control_inst (
    .clk(clk), .rst(rst), .ce(ce),
    .chan_a_ctl_wr(wr[0]), .chan_a_ctl_wdata(wd[0]), .chan_a_modem_control(mc[0]),
    .chan_a_irq_req(irq_req[0]), .chan_a_tx_valid(tx_valid[0]), .chan_a_tx_data(txd[0]),
    .chan_a_tx_ready(rdy[0]), .chan_a_modem_status(st[0]), .chan_a_rx_level(rxl[0]),
    .chan_a_irq_out(irq[0]), .chan_a_irq_oe(oe[0]), .chan_a_aux_out_n(aux[0]),
    .chan_a_serial_out(sout[0]), .chan_a_serial_in(sin[0]), .chan_a_request_send_n(rts[0]),
    .chan_a_terminal_ready_n(dtr[0]), .chan_a_clear_send_n(hs[0].cts_n), .chan_a_set_ready_n(hs[0].dsr_n),
    .chan_a_carrier_n(hs[0].cd_n), .chan_a_ring_n(hs[0].ri_n),
    .chan_b_ctl_wr(wr[1]), .chan_b_ctl_wdata(wd[1]), .chan_b_modem_control(mc[1]),
    .chan_b_irq_req(irq_req[1]), .chan_b_tx_valid(tx_valid[1]), .chan_b_tx_data(txd[1]),
    .chan_b_tx_ready(rdy[1]), .chan_b_modem_status(st[1]), .chan_b_rx_level(rxl[1]),
    .chan_b_irq_out(irq[1]), .chan_b_irq_oe(oe[1]), .chan_b_aux_out_n(aux[1]),
    .chan_b_serial_out(sout[1]), .chan_b_serial_in(sin[1]), .chan_b_request_send_n(rts[1]),
    .chan_b_terminal_ready_n(dtr[1]), .chan_b_clear_send_n(hs[1].cts_n), .chan_b_set_ready_n(hs[1].dsr_n),
    .chan_b_carrier_n(hs[1].cd_n), .chan_b_ring_n(hs[1].ri_n)
  );

  // One far-end terminal per channel
  serial_term_model serial_term_model_inst_a (.line_in(sout[0]), .line_out(sin[0]), .rx_byte(rb[0]),
    .stop_ok(stop_ok[0]), .rx_count(rc[0]));
  serial_term_model serial_term_model_inst_b (.line_in(sout[1]), .line_out(sin[1]), .rx_byte(rb[1]),
    .stop_ok(stop_ok[1]), .rx_count(rc[1]));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic final_report();
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h got %h", what, exp, got);
    end
  endtask

  // Inputs move one ns after the edge so sampling never races
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Expected pins from a control value: oe, aux_n, rts_n, dtr_n
  function automatic logic [3:0] pins_of(input logic [CTL_WIDTH-1:0] v);
    return {v[CTL_IRQ_EN_BIT], ~v[CTL_IRQ_EN_BIT], ~v[CTL_RTS_BIT], ~v[CTL_DTR_BIT]};
  endfunction

  // Only the addressed channel's strobe rises, as a host select would
  task automatic ctl_write(input int ch, input logic [CTL_WIDTH-1:0] v);
    wd[ch] = v;
    wr[ch] = 1'b1;
    step(1);
    wr[ch] = 1'b0;
    step(1);
  endtask

  task automatic chk_pins(input int ch);
    chk("pins", {4'h0, pins_of(mexp[ch])}, {4'h0, oe[ch], aux[ch], rts[ch], dtr[ch]});
    chk("control", {4'h0, mexp[ch]}, {4'h0, mc[ch]});
  endtask

  // Watchdog, several times the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    c = $urandom(56);
    step(12);
    rst = 1'b0;
    // Reset state of both channels
    for (int ch = 0; ch < 2; ch++)
    begin
      chk_pins(ch);
      chk("idle", 8'h07, {5'h00, sout[ch], rdy[ch], rxl[ch]});
      chk("status", 8'h0F, {4'h0, st[ch]});
    end
    // Control writes, corners first, other channel must not move
    for (int i = 0; i < 24; i++)
    begin
      c = i % 2;
      mexp[c] = (i < 2) ? 4'h8 : (i < 4) ? 4'h0 : 4'($urandom);
      ctl_write(c, mexp[c]);
      chk_pins(0);
      chk_pins(1);
      irq_req = 2'($urandom);
      step(2);
      chk("irq", {6'h00, irq_req}, {6'h00, irq[1], irq[0]});
    end
    // Mid-run reset must bring both channels back to their defaults
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    mexp = '{default: '0};
    for (int ch = 0; ch < 2; ch++)
      chk_pins(ch);
    // Frames with handshake inputs churning underneath
    for (int i = 0; i < 4; i++)
    begin
      c = i % 2;
      b = (i < 2) ? {8{i[0]}} : 8'($urandom);
      n = rc[c];
      txd[c] = b;
      tx_valid[c] = 1'b1;
      step(1);
      tx_valid[c] = 1'b0;
      for (int k = 0; k < 1300 && rc[c] == n; k++)
      begin
        if (k % 100 == 0)
          hs[c] = 4'($urandom);
        step(1);
      end
      chk("frames", 8'(n + 1), 8'(rc[c]));
      chk("tx byte", b, rb[c]);
      chk("stop", 8'h01, {7'h00, stop_ok[c]});
      step(100);
      chk("tx idle", 8'h03, {6'h00, sout[c], rdy[c]});
      hs[c] = 4'($urandom);
      step(4);
      chk("status", {4'h0, hs[c]}, {4'h0, st[c]});
    end
    final_report();
  end
endmodule

`default_nettype wire
